/* File: rtl/core_memory_address_decode.v */
/*
 * Core memory address path: processor address registers behind an
 * AXI4-Lite slave, the inverted shared address bus with limit check,
 * the control board module and half decode, and three X/Y boards.
 * Assumes strobe and timing pins come from an external cycle timing
 * generator, asynchronous to CLK_I, and that software keeps the address
 * steady from the strobe through the end of the write half.
 */
`timescale 1ns/10ps
`include "core_memory_address_decode_regs.vh"

module core_memory_address_decode (
    input  wire        CLK_I,
    input  wire        RST_B_I,
    input  wire [5:0]  S_AXI_AWADDR_I,
    input  wire        S_AXI_AWVALID_I,
    output reg         S_AXI_AWREADY_O,
    input  wire [31:0] S_AXI_WDATA_I,
    input  wire [3:0]  S_AXI_WSTRB_I,
    input  wire        S_AXI_WVALID_I,
    output reg         S_AXI_WREADY_O,
    output reg  [1:0]  S_AXI_BRESP_O,
    output reg         S_AXI_BVALID_O,
    input  wire        S_AXI_BREADY_I,
    input  wire [5:0]  S_AXI_ARADDR_I,
    input  wire        S_AXI_ARVALID_I,
    output reg         S_AXI_ARREADY_O,
    output reg  [31:0] S_AXI_RDATA_O,
    output reg  [1:0]  S_AXI_RRESP_O,
    output reg         S_AXI_RVALID_O,
    input  wire        S_AXI_RREADY_I,
    input  wire        ADDRESS_STROBE_I,
    input  wire        X_DRIVER_READ_TIMING_I,
    input  wire        X_DRIVER_WRITE_TIMING_I,
    input  wire        X_COMMON_READ_TIMING_I,
    input  wire        X_COMMON_WRITE_TIMING_I,
    input  wire        Y_DRIVER_READ_TIMING_I,
    input  wire        Y_DRIVER_WRITE_TIMING_I,
    input  wire        Y_COMMON_READ_TIMING_I,
    input  wire        Y_COMMON_WRITE_TIMING_I,
    output reg  [15:0] SHARED_ADDRESS_LINE_N_O,
    output reg         ADDRESS_LIMIT_FAULT_N_O,
    output reg  [2:0]  MODULE_ADDRESS_STROBE_O,
    output wire [23:0] X_DRIVER_POS_OUT_O,
    output wire [23:0] X_DRIVER_NEG_OUT_O,
    output wire [23:0] X_COMMON_POS_OUT_O,
    output wire [23:0] X_COMMON_NEG_OUT_O,
    output wire [23:0] Y_DRIVER_POS_OUT_O,
    output wire [23:0] Y_DRIVER_NEG_OUT_O,
    output wire [47:0] Y_COMMON_POS_OUT_O,
    output wire [47:0] Y_COMMON_NEG_OUT_O
);
    reg                    rst_meta;
    reg                    rst_n;
    reg [`CTL_WIDTH-1:0]   control;
    reg [`ADDRESS_INCREMENTER_WIDTH-1:0]  address_incrementer;
    reg [15:0]             base_reg_one;
    reg [15:0]             base_reg_two;
    reg [`MAR_WIDTH-1:0]   mem_address_reg;
    reg                    aw_held;
    reg                    w_held;
    reg [5:0]              aw_addr;
    reg [31:0]             w_data;
    reg [3:0]              w_strb;
    reg                    strobe_d;
    reg [2:0]              module_select;
    reg                    lower_half;
    reg [31:0]             read_word;
    reg                    read_ok;
    reg                    write_ok;
    reg [15:0]             next_address;
    wire                   data_cycle_select;
    wire [15:0]            address_register_bus;
    wire [15:0]            base_sel;
    wire [8:0]             pins_sync;
    wire                   strobe_sync;
    wire                   strobe_rise;
    wire [15:0]            line_true;
    wire [2:0]             module_decode;
    wire [31:0]            merged;
    wire                   do_write;

    // release of the async reset is made synchronous to CLK_I
    always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    sync_bits #(
        .WIDTH (9)
    ) u_pin_sync (
        .clk_i   (CLK_I),
        .rst_n_i (rst_n),
        .d_i     ({ADDRESS_STROBE_I,
                   X_DRIVER_READ_TIMING_I, X_DRIVER_WRITE_TIMING_I,
                   X_COMMON_READ_TIMING_I, X_COMMON_WRITE_TIMING_I,
                   Y_DRIVER_READ_TIMING_I, Y_DRIVER_WRITE_TIMING_I,
                   Y_COMMON_READ_TIMING_I, Y_COMMON_WRITE_TIMING_I}),
        .q_o     (pins_sync)
    );

    assign strobe_sync = pins_sync[8];
    assign strobe_rise = strobe_sync & ~strobe_d;

    // register bus slave: address and data may arrive in either order
    assign do_write = aw_held & w_held & ~S_AXI_BVALID_O;
    assign merged   = {w_strb[3] ? w_data[31:24] : read_word_w(aw_addr, 3),
                       w_strb[2] ? w_data[23:16] : read_word_w(aw_addr, 2),
                       w_strb[1] ? w_data[15:8]  : read_word_w(aw_addr, 1),
                       w_strb[0] ? w_data[7:0]   : read_word_w(aw_addr, 0)};

    function [7:0] read_word_w;
        input [5:0] ofs;
        input integer lane;
        reg   [31:0] word;
        begin
            word = 32'h0000_0000;
            case (ofs)
                `OFS_CONTROL:     word = {29'h0, control};
                `OFS_INCREMENTER: word = {18'h0, address_incrementer};
                `OFS_BASE_ONE:    word = {16'h0, base_reg_one};
                `OFS_BASE_TWO:    word = {16'h0, base_reg_two};
                `OFS_MEM_ADDRESS: word = {24'h0, mem_address_reg};
                default:          word = 32'h0000_0000;
            endcase
            read_word_w = word[lane*8 +: 8];
        end
    endfunction

    always @* begin
        write_ok = 1'b1;
        case (aw_addr)
            `OFS_CONTROL:     write_ok = 1'b1;
            `OFS_INCREMENTER: write_ok = 1'b1;
            `OFS_BASE_ONE:    write_ok = 1'b1;
            `OFS_BASE_TWO:    write_ok = 1'b1;
            `OFS_MEM_ADDRESS: write_ok = 1'b1;
            `OFS_STATUS:      write_ok = 1'b1;
            default:          write_ok = 1'b0;
        endcase
    end

    always @* begin
        read_ok   = 1'b1;
        read_word = 32'h0000_0000;
        case (S_AXI_ARADDR_I)
            `OFS_CONTROL:     read_word = {29'h0, control};
            `OFS_INCREMENTER: read_word = {18'h0, address_incrementer};
            `OFS_BASE_ONE:    read_word = {16'h0, base_reg_one};
            `OFS_BASE_TWO:    read_word = {16'h0, base_reg_two};
            `OFS_MEM_ADDRESS: read_word = {24'h0, mem_address_reg};
            `OFS_STATUS: begin
                read_word[15:0] = line_true;
                read_word[`STS_MODULE_LSB +: 3] = module_select;
                read_word[`STS_LOWER_HALF]  = lower_half;
                read_word[`STS_LIMIT_FAULT] = ~ADDRESS_LIMIT_FAULT_N_O;
            end
            default:          read_ok = 1'b0;
        endcase
    end

    always @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= `RESP_OKAY;
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= `RESP_OKAY;
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            aw_addr         <= 6'h00;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held         <= 1'b1;
                aw_addr         <= {S_AXI_AWADDR_I[5:2], 2'b00};
                S_AXI_AWREADY_O <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held         <= 1'b1;
                w_data         <= S_AXI_WDATA_I;
                w_strb         <= S_AXI_WSTRB_I;
                S_AXI_WREADY_O <= 1'b0;
            end
            if (do_write) begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= write_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O  <= 1'b0;
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O  <= 1'b1;
            end
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_ARREADY_O <= 1'b0;
                S_AXI_RVALID_O  <= 1'b1;
                S_AXI_RDATA_O   <= read_word;
                S_AXI_RRESP_O   <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O  <= 1'b0;
                S_AXI_ARREADY_O <= 1'b1;
            end
        end
    end

    // address registers; a software write to the incrementer beats a step
    always @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            control             <= `CTL_RESET;
            address_incrementer <= `ADDRESS_INCREMENTER_RESET;
            base_reg_one        <= `BASE_RESET;
            base_reg_two        <= `BASE_RESET;
            mem_address_reg     <= `MAR_RESET;
        end else begin
            if (do_write && aw_addr == `OFS_CONTROL) begin
                control <= merged[`CTL_WIDTH-1:0];
            end
            if (do_write && aw_addr == `OFS_INCREMENTER) begin
                address_incrementer <= merged[`ADDRESS_INCREMENTER_WIDTH-1:0];
            end else if (strobe_rise && control[`CTL_AUTO_ADDRESS_INCREMENTER] &&
                         !data_cycle_select) begin
                address_incrementer <= address_incrementer +
                                       {{(`ADDRESS_INCREMENTER_WIDTH-1){1'b0}}, 1'b1};
            end
            if (do_write && aw_addr == `OFS_BASE_ONE) begin
                base_reg_one <= merged[15:0];
            end
            if (do_write && aw_addr == `OFS_BASE_TWO) begin
                base_reg_two <= merged[15:0];
            end
            if (do_write && aw_addr == `OFS_MEM_ADDRESS) begin
                mem_address_reg <= merged[`MAR_WIDTH-1:0];
            end
        end
    end

    assign data_cycle_select = control[`CTL_DATA_CYCLE_BIT];
    assign base_sel = control[`CTL_USE_BASE_TWO] ? base_reg_two
                                                 : base_reg_one;
    // low bit of the address register lands on line 16
    assign address_register_bus = base_sel +
        {{(16-`MAR_WIDTH){1'b0}}, mem_address_reg};

    // bit k of next_address is shared line 16-k
    always @* begin
        if (data_cycle_select) begin
            next_address = address_register_bus;
        end else begin
            next_address = {2'b00, address_incrementer};
        end
    end

    assign line_true = ~SHARED_ADDRESS_LINE_N_O;

    // control board: inverted lines 2 and 3 name the module
    assign module_decode[0] = ~line_true[14] & ~line_true[13];
    assign module_decode[1] = ~line_true[14] &  line_true[13];
    assign module_decode[2] =  line_true[14] & ~line_true[13];

    always @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            SHARED_ADDRESS_LINE_N_O <= 16'hffff;
            ADDRESS_LIMIT_FAULT_N_O <= 1'b1;
            MODULE_ADDRESS_STROBE_O <= 3'h0;
            strobe_d                <= 1'b0;
            module_select           <= 3'h0;
            lower_half              <= 1'b0;
        end else begin
            strobe_d <= strobe_sync;
            SHARED_ADDRESS_LINE_N_O <= ~next_address;
            ADDRESS_LIMIT_FAULT_N_O <=
                ~(line_true[15:11] > `ADDRESS_LIMIT);
            // line 1 is ignored by the control board
            MODULE_ADDRESS_STROBE_O <= module_decode &
                                       {3{strobe_rise}};
            if (strobe_rise) begin
                module_select <= module_decode;
                lower_half    <= ~line_true[12];
            end
        end
    end

    genvar m;
    generate
        for (m = 0; m < 3; m = m + 1) begin : g_module
            wire sel;
            assign sel = module_select[m];
            xy_address_board #(
                .FULL_SIZE (m == 0 ? `MOD1_FULL :
                            m == 1 ? `MOD2_FULL : `MOD3_FULL)
            ) u_board (
                .clk_i        (CLK_I),
                .rst_n_i      (rst_n),
                .strobe_i     (MODULE_ADDRESS_STROBE_O[m]),
                .lines_n_i    (SHARED_ADDRESS_LINE_N_O[11:0]),
                .xd_rd_i      (sel & pins_sync[7]),
                .xd_wr_i      (sel & pins_sync[6]),
                .xc_rd_i      (sel & pins_sync[5]),
                .xc_wr_i      (sel & pins_sync[4]),
                .yd_rd_i      (sel & pins_sync[3]),
                .yd_wr_i      (sel & pins_sync[2]),
                .yc_half_rd_i (sel & lower_half & pins_sync[1]),
                .yc_half_wr_i (sel & lower_half & pins_sync[0]),
                .yc_full_rd_i (sel & ~lower_half & pins_sync[1]),
                .yc_full_wr_i (sel & ~lower_half & pins_sync[0]),
                .x_drv_pos_o  (X_DRIVER_POS_OUT_O[m*8 +: 8]),
                .x_drv_neg_o  (X_DRIVER_NEG_OUT_O[m*8 +: 8]),
                .x_com_pos_o  (X_COMMON_POS_OUT_O[m*8 +: 8]),
                .x_com_neg_o  (X_COMMON_NEG_OUT_O[m*8 +: 8]),
                .y_drv_pos_o  (Y_DRIVER_POS_OUT_O[m*8 +: 8]),
                .y_drv_neg_o  (Y_DRIVER_NEG_OUT_O[m*8 +: 8]),
                .y_com_pos_o  (Y_COMMON_POS_OUT_O[m*16 +: 16]),
                .y_com_neg_o  (Y_COMMON_NEG_OUT_O[m*16 +: 16])
            );
        end
    endgenerate
endmodule // core_memory_address_decode

/* File: rtl/core_memory_address_decode_regs.vh */
/*
 * Register offsets, field positions, reset values and fixed limits of the
 * core memory address decode block.
 * Assumes inclusion by bare name from the design file and the test bench.
 */
`ifndef CORE_MEMORY_ADDRESS_DECODE_REGS_VH
`define CORE_MEMORY_ADDRESS_DECODE_REGS_VH

// byte offsets on the register bus
`define OFS_CONTROL         6'h00
`define OFS_INCREMENTER     6'h04
`define OFS_BASE_ONE        6'h08
`define OFS_BASE_TWO        6'h0c
`define OFS_MEM_ADDRESS     6'h10
`define OFS_STATUS          6'h14

// control fields
`define CTL_DATA_CYCLE_BIT  0
`define CTL_USE_BASE_TWO    1
`define CTL_AUTO_ADDRESS_INCREMENTER       2
`define CTL_WIDTH           3
`define CTL_RESET           3'h0

// widths and reset values
`define ADDRESS_INCREMENTER_WIDTH          14
`define ADDRESS_INCREMENTER_RESET          14'h0000
`define BASE_RESET          16'h0000
`define MAR_WIDTH           8
`define MAR_RESET           8'h00

// status fields
`define STS_MODULE_LSB      16
`define STS_LOWER_HALF      19
`define STS_LIMIT_FAULT     20

// highest legal value of shared address lines 1..5
`define ADDRESS_LIMIT       5'h0b

// module size straps: 1 for a full 8K module, 0 for a 4K module
`define MOD1_FULL           1
`define MOD2_FULL           1
`define MOD3_FULL           0

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: rtl/sync_bits.v */
/*
 * Two-flop synchroniser for a vector of independent level signals.
 * Assumes each bit is a slow level; no bit pairing across the vector.
 */
`timescale 1ns/10ps
module sync_bits #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= {WIDTH{1'b0}};
            stable <= {WIDTH{1'b0}};
        end else begin
            meta   <= d_i;
            stable <= meta;
        end
    end

    assign q_o = stable;
endmodule // sync_bits

/* File: rtl/xy_address_board.v */
/*
 * X/Y address board of one core module: address latches and the octal
 * decode of driver and common switch selects with read/write polarity.
 * Assumes timing inputs are already gated to this module only.
 */
`timescale 1ns/10ps
module xy_address_board #(
    parameter FULL_SIZE = 1
) (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        strobe_i,
    input  wire [11:0] lines_n_i,
    input  wire        xd_rd_i,
    input  wire        xd_wr_i,
    input  wire        xc_rd_i,
    input  wire        xc_wr_i,
    input  wire        yd_rd_i,
    input  wire        yd_wr_i,
    input  wire        yc_half_rd_i,
    input  wire        yc_half_wr_i,
    input  wire        yc_full_rd_i,
    input  wire        yc_full_wr_i,
    output reg  [7:0]  x_drv_pos_o,
    output reg  [7:0]  x_drv_neg_o,
    output reg  [7:0]  x_com_pos_o,
    output reg  [7:0]  x_com_neg_o,
    output reg  [7:0]  y_drv_pos_o,
    output reg  [7:0]  y_drv_neg_o,
    output reg  [15:0] y_com_pos_o,
    output reg  [15:0] y_com_neg_o
);
    // latch[11] is line 5 ... latch[0] is line 16, held as true levels
    reg  [11:0] latch;
    wire [7:0]  x_com_sel;
    wire [7:0]  x_drv_sel;
    wire [7:0]  y_drv_sel;
    wire [7:0]  y_com_sel;
    wire [15:0] y_com_en;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch <= 12'h000;
        end else if (strobe_i) begin
            latch <= ~lines_n_i;
        end
    end

    // decode works on the latch complement, so all-true lines pick switch 0
    assign x_com_sel = 8'h01 << (~latch[5:3]);
    assign x_drv_sel = 8'h01 << (~latch[2:0]);
    assign y_drv_sel = 8'h01 << (~latch[8:6]);
    assign y_com_sel = 8'h01 << (~latch[11:9]);

    // a 4K board has no upper common switches fitted
    assign y_com_en = FULL_SIZE ? {y_com_sel, y_com_sel}
                                : {8'h00, y_com_sel};

    // 64 X lines times 128 Y lines give 8192 words per full-size module; a 4K board has 64 Y lines
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            x_drv_pos_o <= 8'h00;
            x_drv_neg_o <= 8'h00;
            x_com_pos_o <= 8'h00;
            x_com_neg_o <= 8'h00;
            y_drv_pos_o <= 8'h00;
            y_drv_neg_o <= 8'h00;
            y_com_pos_o <= 16'h0000;
            y_com_neg_o <= 16'h0000;
        end else begin
            x_drv_pos_o <= x_drv_sel & {8{xd_rd_i}};
            x_com_neg_o <= x_com_sel & {8{xc_rd_i}};
            x_drv_neg_o <= x_drv_sel & {8{xd_wr_i}};
            x_com_pos_o <= x_com_sel & {8{xc_wr_i}};
            y_drv_neg_o <= y_drv_sel & {8{yd_rd_i}};
            y_drv_pos_o <= y_drv_sel & {8{yd_wr_i}};
            y_com_pos_o <= y_com_en & {{8{yc_full_rd_i}},
                                       {8{yc_half_rd_i}}};
            y_com_neg_o <= y_com_en & {{8{yc_full_wr_i}},
                                       {8{yc_half_wr_i}}};
        end
    end
endmodule // xy_address_board

/* File: verif/core_memory_address_decode_properties.sv */
/* Pin-level checks of the core memory address decode block.
   Assumes read and write timing levels never overlap. */
`timescale 1ns/10ps
module core_memory_address_decode_properties (
    input wire        CLK_I,
    input wire        RST_B_I,
    input wire [15:0] SHARED_ADDRESS_LINE_N_O,
    input wire        ADDRESS_LIMIT_FAULT_N_O,
    input wire [2:0]  MODULE_ADDRESS_STROBE_O,
    input wire        X_DRIVER_READ_TIMING_I,
    input wire        X_DRIVER_WRITE_TIMING_I,
    input wire        X_COMMON_READ_TIMING_I,
    input wire        Y_COMMON_READ_TIMING_I,
    input wire [23:0] X_DRIVER_POS_OUT_O,
    input wire [23:0] X_DRIVER_NEG_OUT_O,
    input wire [23:0] X_COMMON_NEG_OUT_O,
    input wire [47:0] Y_COMMON_POS_OUT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // inverted lines 1..5 >= 5'h14 means within limit
    limit_fault_a: assert property (ADDRESS_LIMIT_FAULT_N_O ==
        ($past(SHARED_ADDRESS_LINE_N_O[15:11]) >= 5'h14))
        else $error("limit fault flag wrong");
    strobe_decode_a: assert property (MODULE_ADDRESS_STROBE_O != 3'h0 |->
        MODULE_ADDRESS_STROBE_O == {SHARED_ADDRESS_LINE_N_O[14:13] == 2'b01,
        SHARED_ADDRESS_LINE_N_O[14:13] == 2'b10,
        SHARED_ADDRESS_LINE_N_O[14:13] == 2'b11}) else $error("bad strobe");
    strobe_pulse_a: assert property (MODULE_ADDRESS_STROBE_O != 3'h0 |=>
        MODULE_ADDRESS_STROBE_O == 3'h0) else $error("strobe too long");
    xd_read_a: assert property (X_DRIVER_POS_OUT_O != 24'h0 |->
        $past(X_DRIVER_READ_TIMING_I, 3)) else $error("x drv pos no read");
    xc_read_a: assert property (X_COMMON_NEG_OUT_O != 24'h0 |->
        $past(X_COMMON_READ_TIMING_I, 3)) else $error("x com neg no read");
    xd_write_a: assert property (X_DRIVER_NEG_OUT_O != 24'h0 |->
        $past(X_DRIVER_WRITE_TIMING_I, 3)) else $error("x drv neg no write");
    yc_read_a: assert property (Y_COMMON_POS_OUT_O != 48'h0 |->
        $past(Y_COMMON_READ_TIMING_I, 3)) else $error("y com pos no read");
    x_onehot_a: assert property ($onehot0(X_DRIVER_POS_OUT_O) &&
        $onehot0(X_COMMON_NEG_OUT_O)) else $error("several x switches");
    yc_onehot_a: assert property ($onehot0(Y_COMMON_POS_OUT_O))
        else $error("several y commons");
    small_module_a: assert property (Y_COMMON_POS_OUT_O[47:40] == 8'h00)
        else $error("upper commons on small module");
    x_hold_a: assert property (X_DRIVER_POS_OUT_O != 24'h0 &&
        $past(X_DRIVER_POS_OUT_O) != 24'h0 |-> $stable(X_DRIVER_POS_OUT_O))
        else $error("x line moved in half");
    cover property (MODULE_ADDRESS_STROBE_O == 3'h4);
    cover property (!ADDRESS_LIMIT_FAULT_N_O);
    cover property (Y_COMMON_POS_OUT_O[31:24] != 8'h00);
endmodule // core_memory_address_decode_properties

/* File: verif/core_cycle_timing_model.sv */
/* Cycle timing generator model: address strobe and the timing levels
   of the read and write halves. Assumes tasks are called in order. */
`timescale 1ns/10ps
module core_cycle_timing_model (
    input  wire       clk_i,
    output reg        strobe_o = 1'b0,
    output reg  [3:0] rd_o = 4'h0,
    output reg  [3:0] wr_o = 4'h0
);
    // one strobe per cycle; the block routes it to one module
    task run_strobe;
        @(posedge clk_i);
        strobe_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        strobe_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
    endtask
    // bits: x driver, x common, y driver, y common
    task run_half(input reg wr, input reg on);
        @(posedge clk_i);
        if (wr) wr_o <= {4{on}};
        else rd_o <= {4{on}};
        repeat (4) @(posedge clk_i);
        #1;
    endtask
endmodule // core_cycle_timing_model

/* File: verif/core_memory_address_decode_test.sv */
/* Self-checking bench of the core memory address decode block.
   Assumes the timing model drives the strobe and timing pins. */
`timescale 1ns/10ps
`include "core_memory_address_decode_regs.vh"
module core_memory_address_decode_test;
    reg          clk = 1'b0;
    reg          rst_n = 1'b0;
    reg  [5:0]   aw = 6'h00, ar = 6'h00;
    reg  [31:0]  wd = 32'h0, b;
    reg          awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    wire         awr, wrdy, bv, arr, rv, flt, stb;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [15:0]  bus;
    wire [2:0]   mstb;
    wire [3:0]   rd_t, wr_t;
    wire [23:0]  xdp, xdn, xcp, xcn, ydp, ydn;
    wire [47:0]  ycp, ycn;
    integer      fails = 0, cmp_count = 0, seed = 93, n, m, h;
    reg  [69:0]  q[$];
    reg  [15:0]  a;
    reg  [7:0]   mr;
    reg  [2:0]   seen;
    reg  [119:0] e;
    always #2.5 clk = ~clk;
    core_memory_address_decode core_memory_address_decode_inst (
        .CLK_I(clk), .RST_B_I(rst_n), .S_AXI_AWADDR_I(aw),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
        .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rre), .ADDRESS_STROBE_I(stb),
        .X_DRIVER_READ_TIMING_I(rd_t[3]), .X_DRIVER_WRITE_TIMING_I(wr_t[3]),
        .X_COMMON_READ_TIMING_I(rd_t[2]), .X_COMMON_WRITE_TIMING_I(wr_t[2]),
        .Y_DRIVER_READ_TIMING_I(rd_t[1]), .Y_DRIVER_WRITE_TIMING_I(wr_t[1]),
        .Y_COMMON_READ_TIMING_I(rd_t[0]), .Y_COMMON_WRITE_TIMING_I(wr_t[0]),
        .SHARED_ADDRESS_LINE_N_O(bus), .ADDRESS_LIMIT_FAULT_N_O(flt),
        .MODULE_ADDRESS_STROBE_O(mstb), .X_DRIVER_POS_OUT_O(xdp),
        .X_DRIVER_NEG_OUT_O(xdn), .X_COMMON_POS_OUT_O(xcp),
        .X_COMMON_NEG_OUT_O(xcn), .Y_DRIVER_POS_OUT_O(ydp),
        .Y_DRIVER_NEG_OUT_O(ydn), .Y_COMMON_POS_OUT_O(ycp),
        .Y_COMMON_NEG_OUT_O(ycn));
    core_cycle_timing_model core_cycle_timing_model_inst (
        .clk_i(clk), .strobe_o(stb), .rd_o(rd_t), .wr_o(wr_t));
    task chk(input [119:0] s, input [119:0] x);
        cmp_count = cmp_count + 1;
        if (s !== x) begin
            fails = fails + 1;
            $display("BAD %0t: seen %h want %h", $time, s, x);
        end
    endtask
    // queue entry: offset, read mask, read value
    task wr(input [5:0] o, input [31:0] d);
        @(posedge clk);
        aw <= o;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        q.push_back({o, 64'h0});
        while (!bv) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end
        bre <= 1'b0;
    endtask
    task rd(input [5:0] o, input [31:0] x, input [31:0] mk);
        @(posedge clk);
        ar <= o;
        arv <= 1'b1;
        rre <= 1'b1;
        q.push_back({o, mk, x});
        while (!rv) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end
        rre <= 1'b0;
    endtask
    always @(posedge clk) if ((bv && bre) || (rv && rre)) begin
        chk({86'h0, bv ? bresp : rresp, rdata & q[0][63:32]},
            {86'h0, q[0][69:64] > `OFS_STATUS ? `RESP_SLVERR : `RESP_OKAY,
            q[0][31:0]});
        q.delete(0);
    end
    always @(posedge clk) if (mstb !== 3'h0) seen <= mstb;
    task end_of_test;
        $display("compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        fails = fails + 1;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`OFS_CONTROL, 32'h0, 32'h7);
        wr(6'h18, 32'h0);
        $display("test reset and map done");
        b = $random(seed);
        wr(`OFS_INCREMENTER, {18'h0, b[13:0]});
        wr(`OFS_CONTROL, 32'h4);
        core_cycle_timing_model_inst.run_strobe;
        b = b + 1;
        repeat (2) @(posedge clk);
        #1;
        chk({104'h0, bus}, {104'h0, ~{2'b00, b[13:0]}});
        rd(`OFS_STATUS, {18'h0, b[13:0]}, 32'hffff);
        $display("test incrementer done");
        // first two passes straddle the limit on base one
        for (n = 0; n < 4; n = n + 1) begin
            b = (n < 2) ? 32'h5fff : $random(seed);
            mr = (n < 2) ? n[7:0] : b[23:16];
            wr(`OFS_BASE_ONE, {16'h0, b[15:0]});
            wr(`OFS_BASE_TWO, {16'h0, ~b[15:0]});
            wr(`OFS_MEM_ADDRESS, {24'h0, mr});
            wr(`OFS_CONTROL, {30'h0, n[1], 1'b1});
            a = (n[1] ? ~b[15:0] : b[15:0]) + {8'h0, mr};
            repeat (3) @(posedge clk);
            #1;
            chk({103'h0, flt, bus}, {103'h0, a[15:11] <= `ADDRESS_LIMIT,
                ~a});
            rd(`OFS_STATUS, {11'h0, a[15:11] > `ADDRESS_LIMIT, 4'h0, a},
                32'h0010ffff);
        end
        $display("test address path done");
        for (n = 0; n < 6; n = n + 1) begin
            m = n / 2;
            h = n % 2;
            b = $random(seed);
            a = {1'b0, m[1:0], h[0], b[11:0]};
            wr(`OFS_BASE_ONE, {16'h0, a});
            wr(`OFS_MEM_ADDRESS, 32'h0);
            wr(`OFS_CONTROL, 32'h1);
            seen = 3'h0;
            core_cycle_timing_model_inst.run_strobe;
            chk({117'h0, seen}, {117'h0, 3'h1 << m});
            e = {24'h1 << (m * 8 + 7 - a[2:0]), 24'h1 << (m * 8 + 7 - a[5:3]),
                24'h1 << (m * 8 + 7 - a[8:6]), (m == 2 && h == 1 &&
                !`MOD3_FULL) ? 48'h0 : 48'h1 << (m * 16 + h * 8 + 7 - a[11:9])};
            core_cycle_timing_model_inst.run_half(1'b0, 1'b1);
            chk({xdp, xcn, ydn, ycp}, e);
            core_cycle_timing_model_inst.run_half(1'b0, 1'b0);
            core_cycle_timing_model_inst.run_half(1'b1, 1'b1);
            chk({xdn, xcp, ydp, ycn}, e);
            core_cycle_timing_model_inst.run_half(1'b1, 1'b0);
        end
        $display("test module cycles done");
        end_of_test;
    end
endmodule // core_memory_address_decode_test
bind core_memory_address_decode core_memory_address_decode_properties
    core_memory_address_decode_properties_inst (.*);
